// ### hdl/amc_pkg.sv
package amc_pkg;
  // clock and rate limits
  localparam int CLK_HZ = 25000000;
  localparam int RATE10_SPS = 1100000;
  localparam int RATE12_SPS = 500000;
  // least clock cycles per sample, rounded up
  localparam int MIN10_CYC = (CLK_HZ + RATE10_SPS - 1) / RATE10_SPS;
  localparam int MIN12_CYC = (CLK_HZ + RATE12_SPS - 1) / RATE12_SPS;
  // converter shape
  localparam int NUM_AIN = 13;
  localparam int NUM_SH = 4;
  localparam int CODE_W = 12;
  localparam int BITS10 = 10;
  localparam int BITS12 = 12;
  // register byte offsets
  localparam logic [7:0] OFS_CTL1 = 8'h00;
  localparam logic [7:0] OFS_CTL2 = 8'h04;
  localparam logic [7:0] OFS_CTL3 = 8'h08;
  localparam logic [7:0] OFS_PCFGL = 8'h0c;
  localparam logic [7:0] OFS_PCFGH = 8'h10;
  localparam logic [7:0] OFS_CHSEL = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_CLR = 8'h1c;
  localparam logic [7:0] OFS_IEN = 8'h20;
  localparam logic [7:0] OFS_RES0 = 8'h24;
  // field positions
  localparam int CTL1_ON = 15;
  localparam int CTL1_RES = 10;
  localparam int CTL1_FMT = 8;
  localparam int CTL1_TRIG = 5;
  localparam int CTL1_GO = 1;
  localparam int CTL1_IDLE = 0;
  localparam int CTL2_VREF = 13;
  localparam int CTL2_SHN = 8;
  localparam int CTL3_SAMT = 8;
  localparam int CTL3_DIV = 0;
  // writable bits and reset value
  localparam logic [15:0] CTL1_WMASK = 16'h87e0;
  localparam logic [15:0] CTL2_WMASK = 16'he300;
  localparam logic [15:0] CTL3_WMASK = 16'h1fff;
  localparam logic [15:0] REG_RST = 16'h0000;
  // trigger and format codes
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [1:0] FMT_INT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  // status bits
  localparam int ST_DONE = 0;
  localparam int ST_LOST = 1;
  localparam int ST_W = 2;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hdl/amc_seq_if.sv
interface amc_seq_if;
  logic ce; // clock enable
  logic on; // module switched on
  logic res12; // 12-bit single-hold mode
  logic go; // one-cycle start
  logic auto; // free-running restart
  logic [1:0] fmt; // result format
  logic [1:0] shn; // hold channel count code
  logic [4:0] samt; // sample time in tad
  logic [7:0] div; // tad divider
  logic [15:0] amask; // analog pin marks
  logic [15:0] chsel; // input per hold channel
  logic done; // conversion set complete
  logic lost; // start while busy
  logic busy; // sequence running
  logic [63:0] res; // four formatted results
  logic [3:0] sh_act; // holds tracking
  modport ctl (output ce, on, res12, go, auto, fmt, shn, samt, div, amask, chsel,
    input done, lost, busy, res, sh_act);
  modport seq (input ce, on, res12, go, auto, fmt, shn, samt, div, amask, chsel,
    output done, lost, busy, res, sh_act);
endinterface

// ### hdl/amc_seq.sv
module amc_seq
  import amc_pkg::*;
#(
  parameter int NCH = NUM_AIN
)(
  input wire logic aclk,
  input wire logic aresetn,
  amc_seq_if.seq sif,
  input wire logic [NCH*CODE_W-1:0] ain
);
  ////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {SQ_IDLE, SQ_SAMPLE, SQ_CONV} amc_sq_e;
  amc_sq_e state_r, state_nxt; // sequence state
  logic [7:0] tad_r, tad_nxt; // tad divider count
  logic [5:0] step_r, step_nxt; // tad steps in phase
  logic [7:0] rate_r, rate_nxt; // cycles since start
  logic [CODE_W-1:0] held_r [NUM_SH]; // held codes
  logic [CODE_W-1:0] held_nxt [NUM_SH];
  logic [63:0] res_r, res_nxt; // formatted results
  logic done_r, done_nxt, lost_r, lost_nxt;
  logic [3:0] act_r, act_nxt; // holds tracking
  logic [CODE_W-1:0] pick [NUM_SH]; // input seen per hold
  logic [15:0] fval [NUM_SH]; // formatted per hold
  logic [3:0] nmask; // holds in use
  logic [5:0] conv_len; // tads of conversion
  logic [7:0] min_cyc; // rate floor in cycles
  logic tad_tick;

  ////////////////////////////////////////////////////////////
  // holds in use: one in 12-bit, up to four in 10-bit
  always_comb
  begin
    if (sif.res12)
      nmask = 4'h1;
    else if (sif.shn == 2'h0)
      nmask = 4'h1;
    else if (sif.shn == 2'h1)
      nmask = 4'h3;
    else
      nmask = 4'hf;
  end

  // conversion length and rate floor
  always_comb
  begin
    conv_len = sif.res12 ? 6'(BITS12) : 6'(BITS10) * 6'(nmask[3] ? 4 : nmask[1] ? 2 : 1);
    min_cyc = sif.res12 ? 8'(MIN12_CYC) : 8'(MIN10_CYC) * 8'(nmask[3] ? 4 : nmask[1] ? 2 : 1);
  end
  assign tad_tick = (tad_r == sif.div);

  ////////////////////////////////////////////////////////////
  // per hold: pick input, format held code
  for (genvar k = 0; k < NUM_SH; k++)
  begin : g_sh
    logic [3:0] ch;
    logic ok;
    logic [CODE_W-1:0] h;
    assign ch = sif.chsel[4*k +: 4];
    assign ok = (int'(ch) < NCH) && sif.amask[ch];
    assign pick[k] = ok ? ain[int'(ch)*CODE_W +: CODE_W] : '0;
    assign h = held_r[k];
    always_comb
    begin
      case (sif.fmt)
        FMT_INT: fval[k] = sif.res12 ? {4'h0, h} : {6'h00, h[11:2]};
        FMT_SINT: fval[k] = sif.res12 ? {{5{~h[11]}}, h[10:0]} : {{7{~h[11]}}, h[10:2]};
        FMT_FRAC: fval[k] = sif.res12 ? {h, 4'h0} : {h[11:2], 6'h00};
        default: fval[k] = sif.res12 ? {~h[11], h[10:0], 4'h0} : {~h[11], h[10:2], 6'h00};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // sequence next state; sleep and idle do not stop it
  always_comb
  begin
    state_nxt = state_r;
    step_nxt = step_r;
    held_nxt = held_r;
    res_nxt = res_r;
    act_nxt = act_r;
    done_nxt = 1'b0;
    lost_nxt = 1'b0;
    tad_nxt = (state_r == SQ_IDLE || tad_tick) ? 8'h00 : tad_r + 8'h01;
    rate_nxt = (state_r != SQ_IDLE && rate_r != 8'hff) ? rate_r + 8'h01 : rate_r;
    case (state_r)
      SQ_IDLE:
      begin
        if (sif.go || sif.auto)
        begin
          state_nxt = SQ_SAMPLE;
          step_nxt = 6'h00;
          rate_nxt = 8'h00;
          act_nxt = nmask;
        end
      end
      SQ_SAMPLE:
      begin
        if (tad_tick)
        begin
          step_nxt = step_r + 6'h01;
          // all holds captured on the same edge
          if (step_r + 6'h01 >= ((sif.samt == 5'h00) ? 6'h01 : {1'b0, sif.samt}))
          begin
            for (int k = 0; k < NUM_SH; k++)
              held_nxt[k] = nmask[k] ? pick[k] : '0;
            state_nxt = SQ_CONV;
            step_nxt = 6'h00;
            act_nxt = 4'h0;
          end
        end
      end
      SQ_CONV:
      begin
        if (tad_tick && step_r < conv_len)
          step_nxt = step_r + 6'h01;
        // finish only when bits are done and the rate floor is met
        if (step_r >= conv_len && rate_r >= min_cyc)
        begin
          for (int k = 0; k < NUM_SH; k++)
            res_nxt[16*k +: 16] = nmask[k] ? fval[k] : 16'h0000;
          done_nxt = 1'b1;
          state_nxt = SQ_IDLE;
        end
      end
      default: state_nxt = SQ_IDLE;
    endcase
    if (sif.go && state_r != SQ_IDLE)
      lost_nxt = 1'b1;
    // off: no sampling, no conversion
    if (!sif.on)
    begin
      state_nxt = SQ_IDLE;
      act_nxt = 4'h0;
    end
  end

  // sequence registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= SQ_IDLE;
      tad_r <= 8'h00;
      step_r <= 6'h00;
      rate_r <= 8'h00;
      held_r <= '{default: '0};
      res_r <= 64'h0;
      done_r <= 1'b0;
      lost_r <= 1'b0;
      act_r <= 4'h0;
    end
    else if (sif.ce)
    begin
      state_r <= state_nxt;
      tad_r <= tad_nxt;
      step_r <= step_nxt;
      rate_r <= rate_nxt;
      held_r <= held_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
      lost_r <= lost_nxt;
      act_r <= act_nxt;
    end
  end

  assign sif.done = done_r;
  assign sif.lost = lost_r;
  assign sif.busy = (state_r != SQ_IDLE);
  assign sif.res = res_r;
  assign sif.sh_act = act_r;

  ////////////////////////////////////////////////////////////
  // checks
  idle_when_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sif.on && sif.ce) |=> (state_r == SQ_IDLE && act_r == 4'h0))
    else $error("sequence active while off");
  single_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sif.res12 && state_r == SQ_SAMPLE) |-> (act_r == 4'h1))
    else $error("several holds in 12-bit mode");
  four_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sif.res12 && sif.shn[1] && sif.ce && state_r == SQ_IDLE && sif.go && sif.on) |=> (act_r == 4'hf))
    else $error("four holds not sampling together");
  rate_floor_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(done_r) |-> (rate_r >= min_cyc))
    else $error("conversion faster than rate limit");
  unmarked_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == SQ_SAMPLE && state_nxt == SQ_CONV && !sif.amask[sif.chsel[3:0]] && sif.ce)
    |=> (held_r[0] == '0))
    else $error("unmarked pin was converted");
  frac_align_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_nxt && sif.ce && sif.fmt == FMT_FRAC && sif.res12) |=> (res_r[3:0] == 4'h0))
    else $error("fractional result not left aligned");
  done_12_c: cover property (@(posedge aclk) disable iff (!aresetn) done_r && sif.res12);
  done_quad_c: cover property (@(posedge aclk) disable iff (!aresetn) done_r && res_r[63:48] != 16'h0);
  lost_c: cover property (@(posedge aclk) disable iff (!aresetn) lost_r);
endmodule

// ### hdl/amc_top.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
module amc_top
  import amc_pkg::*;
#(
  parameter int NCH = NUM_AIN,
  parameter int ADDR_W = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH*CODE_W-1:0] ain,
  input wire logic ext_trig,
  output logic irq,
  output logic [2:0] vref_select,
  output logic [3:0] sh_active
);
  ////////////////////////////////////////////////////////////
  amc_seq_if sif(); // link to sequencer
  // bus state
  logic aw_hold_r, aw_hold_nxt; // write address held
  logic w_hold_r, w_hold_nxt; // write data held
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_do; // write performed this cycle
  logic wr_hit; // write address mapped
  logic [15:0] rd_val; // read mux value
  logic rd_hit; // read address mapped
  // register state
  logic [15:0] ctl1_r, ctl1_nxt, ctl2_r, ctl2_nxt, ctl3_r, ctl3_nxt;
  logic [15:0] pcfgl_r, pcfgl_nxt, pcfgh_r, pcfgh_nxt;
  logic [15:0] chsel_r, chsel_nxt;
  logic [ST_W-1:0] stat_r, stat_nxt, ien_r, ien_nxt, clr;
  logic go_r, go_nxt, irq_r, irq_nxt;
  logic [2:0] trig; // trigger source

  // 16-bit register write with byte lanes
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
    input logic [3:0] s, input logic [15:0] m);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]} & m;
  endfunction

  ////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    wr_hit = (awaddr_r[1:0] == 2'h0) && (awaddr_r <= OFS_RES0 + 8'h0c);
    rd_hit = (s_axi_araddr[1:0] == 2'h0) && ({{(8){1'b0}}, s_axi_araddr} <= 16'(OFS_RES0 + 8'h0c));
    rd_val = 16'h0000;
    case (8'(s_axi_araddr))
      OFS_CTL1: rd_val = ctl1_r | {15'h0000, !sif.busy};
      OFS_CTL2: rd_val = ctl2_r;
      OFS_CTL3: rd_val = ctl3_r;
      OFS_PCFGL: rd_val = pcfgl_r;
      OFS_PCFGH: rd_val = pcfgh_r;
      OFS_CHSEL: rd_val = chsel_r;
      OFS_STAT: rd_val = {14'h0000, stat_r};
      OFS_IEN: rd_val = {14'h0000, ien_r};
      OFS_RES0: rd_val = sif.res[15:0];
      OFS_RES0 + 8'h04: rd_val = sif.res[31:16];
      OFS_RES0 + 8'h08: rd_val = sif.res[47:32];
      OFS_RES0 + 8'h0c: rd_val = sif.res[63:48];
      default: rd_val = 16'h0000; // clear register reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////
  // bus next state: address and data taken in either order
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    wr_do = aw_hold_r && w_hold_r && !bvalid_r;
    // capture write address
    if (awready_r && s_axi_awvalid)
    begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = 8'(s_axi_awaddr);
    end
    // capture write data
    if (wready_r && s_axi_wvalid)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    // both held: perform and answer
    if (wr_do)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    // read answer
    if (arready_r && s_axi_arvalid)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {16'h0000, rd_val};
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
    end
    else if (ce)
    begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // register next state
  always_comb
  begin
    ctl1_nxt = ctl1_r;
    ctl2_nxt = ctl2_r;
    ctl3_nxt = ctl3_r;
    pcfgl_nxt = pcfgl_r;
    pcfgh_nxt = pcfgh_r;
    chsel_nxt = chsel_r;
    ien_nxt = ien_r;
    clr = '0;
    go_nxt = 1'b0;
    trig = ctl1_r[CTL1_TRIG +: 3];
    if (wr_do)
    begin
      case (awaddr_r)
        OFS_CTL1:
        begin
          ctl1_nxt = merge(ctl1_r, wdata_r, wstrb_r, CTL1_WMASK);
          if (ctl1_r[CTL1_ON])
            ctl1_nxt[CTL1_RES] = ctl1_r[CTL1_RES];
          go_nxt = ctl1_r[CTL1_ON] && (trig == TRIG_SW) && wstrb_r[0] && wdata_r[CTL1_GO];
        end
        OFS_CTL2: ctl2_nxt = merge(ctl2_r, wdata_r, wstrb_r, CTL2_WMASK);
        OFS_CTL3: ctl3_nxt = merge(ctl3_r, wdata_r, wstrb_r, CTL3_WMASK);
        OFS_PCFGL: pcfgl_nxt = merge(pcfgl_r, wdata_r, wstrb_r, 16'hffff);
        OFS_PCFGH: pcfgh_nxt = merge(pcfgh_r, wdata_r, wstrb_r, 16'hffff);
        OFS_CHSEL: chsel_nxt = merge(chsel_r, wdata_r, wstrb_r, 16'hffff);
        OFS_CLR: clr = wstrb_r[0] ? wdata_r[ST_W-1:0] : '0;
        OFS_IEN: ien_nxt = wstrb_r[0] ? wdata_r[ST_W-1:0] : ien_r;
        default: ;
      endcase
    end
    // external trigger for the non-software, non-auto sources
    if (ctl1_r[CTL1_ON] && trig != TRIG_SW && trig != TRIG_AUTO && ext_trig)
      go_nxt = 1'b1;
    // sticky status: a new event beats a clear
    stat_nxt = (stat_r & ~clr) | {sif.lost, sif.done};
    irq_nxt = |(stat_nxt & ien_nxt);
  end

  // register state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl1_r <= REG_RST;
      ctl2_r <= REG_RST;
      ctl3_r <= REG_RST;
      pcfgl_r <= REG_RST;
      pcfgh_r <= REG_RST;
      chsel_r <= REG_RST;
      stat_r <= '0;
      ien_r <= '0;
      go_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else if (ce)
    begin
      ctl1_r <= ctl1_nxt;
      ctl2_r <= ctl2_nxt;
      ctl3_r <= ctl3_nxt;
      pcfgl_r <= pcfgl_nxt;
      pcfgh_r <= pcfgh_nxt;
      chsel_r <= chsel_nxt;
      stat_r <= stat_nxt;
      ien_r <= ien_nxt;
      go_r <= go_nxt;
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // sequencer hookup
  assign sif.ce = ce;
  assign sif.on = ctl1_r[CTL1_ON];
  assign sif.res12 = ctl1_r[CTL1_RES];
  assign sif.go = go_r;
  assign sif.auto = (trig == TRIG_AUTO);
  assign sif.fmt = ctl1_r[CTL1_FMT +: 2];
  assign sif.shn = ctl2_r[CTL2_SHN +: 2];
  assign sif.samt = ctl3_r[CTL3_SAMT +: 5];
  assign sif.div = ctl3_r[CTL3_DIV +: 8];
  assign sif.amask = pcfgl_r;
  assign sif.chsel = chsel_r;

  amc_seq #(.NCH(NCH)) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .sif(sif),
    .ain(ain)
  );

  // outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = irq_r;
  assign vref_select = ctl2_r[CTL2_VREF +: 3];
  assign sh_active = sif.sh_act;

  ////////////////////////////////////////////////////////////
  // checks
  res_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctl1_r[CTL1_ON] && $past(ctl1_r[CTL1_ON])) |-> $stable(ctl1_r[CTL1_RES]))
    else $error("resolution changed while on");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_r == |(stat_r & ien_r))
    else $error("interrupt level mismatch");
  done_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sif.done && ce) |=> stat_r[ST_DONE])
    else $error("done event lost");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_do && ce) |=> (s_axi_bvalid && !s_axi_awready && !s_axi_wready))
    else $error("write not answered");
  go_needs_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go_r |-> $past(ctl1_r[CTL1_ON]))
    else $error("start issued while off");
  wr_c: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  irq_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_r));
endmodule

// ### tb/amc_src.sv
module amc_src
  import amc_pkg::*;
(
  input wire logic aclk,
  input wire logic fire,
  output logic [NUM_AIN*CODE_W-1:0] ain,
  output logic ext_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // steady level per pin, trigger one cycle after request
  initial
  begin
    ain = '0;
    ext_trig = 1'b0;
  end
  always @(posedge aclk)
  begin
    for (int n = 0; n < NUM_AIN; n++)
      ain[n*CODE_W +: CODE_W] <= 12'h0a5 + 12'h111 * n;
    ext_trig <= fire;
  end
endmodule

// ### tb/adc_mode_and_setup_control_bench.sv
module adc_mode_and_setup_control_bench
  import amc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq, ext_trig;
  logic [1:0] bresp, rresp;
  logic [2:0] vref_select;
  logic [3:0] sh_active, seen;
  logic [NUM_AIN*CODE_W-1:0] ain;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  logic allf;
  always #20 aclk = ~aclk;
  amc_src src (.aclk(aclk), .fire(fire), .ain(ain), .ext_trig(ext_trig));
  amc_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ain(ain), .ext_trig(ext_trig),
    .irq(irq), .vref_select(vref_select), .sh_active(sh_active));
  ////////////////////////////////////////
  // verdict and hang guard
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [11:0] lvl(input int c);
    lvl = 12'h0a5 + 12'h111 * c;
  endfunction
  ////////////////////////////////////////
  // bus master tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    while (bvalid !== 1'b1);
    bready <= 0;
    // let an edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
    // let an edge pass so a following call never re-raises rready in this step
    @(posedge aclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  // counts cycles to irq, gathering hold activity
  task automatic wirq();
    n = 0;
    seen = '0;
    allf = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      @(posedge aclk);
      n++;
      seen = seen | sh_active;
      allf = allf | (sh_active === 4'hf);
    end
  endtask
  ////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk("ctl1", OFS_CTL1, 32'h0001);
    rchk("ctl2", OFS_CTL2, 32'h0000);
    chk("irq", irq, 0);
    rd(8'h34, d, r);
    chk("bad_resp", r, RESP_SLVERR);
    chk("bad_data", d, 0);
  endtask
  task automatic t_quad();
    wr(OFS_PCFGL, 16'h1021);
    wr(OFS_CHSEL, 16'hc850);
    wr(OFS_CTL2, 16'ha200);
    wr(OFS_CTL3, 16'h0201);
    chk("vref", vref_select, 3'h5);
    rchk("ctl2", OFS_CTL2, 32'ha200);
    rchk("ctl3", OFS_CTL3, 32'h0201);
    wr(OFS_CLR, 16'h0003);
    wr(OFS_IEN, 16'h0001);
    wr(OFS_CTL1, 16'h8000);
    wr(OFS_CTL1, 16'h8002);
    wirq();
    chk("all_holds", allf, 1);
    chk("rate10", n >= 4 * MIN10_CYC - 2, 1);
    rchk("hold0", OFS_RES0, lvl(0) >> 2);
    rchk("hold1", OFS_RES0 + 8'h04, lvl(5) >> 2);
    rchk("hold2", OFS_RES0 + 8'h08, 0);
    rchk("hold3", OFS_RES0 + 8'h0c, lvl(12) >> 2);
    wr(OFS_CLR, 16'h0001);
    chk("irq_clr", irq, 0);
  endtask
  task automatic t_single();
    wr(OFS_CTL1, 16'h8400);
    rchk("res_locked", OFS_CTL1, 32'h8001);
    wr(OFS_CTL1, 16'h0000);
    wr(OFS_CTL1, 16'h0400);
    // switch on first, start only once the module is on
    wr(OFS_CTL1, 16'h8400);
    wr(OFS_CTL1, 16'h8402);
    wirq();
    chk("one_hold", seen, 4'h1);
    chk("rate12", n >= MIN12_CYC - 2, 1);
    rchk("hold0_12", OFS_RES0, lvl(0));
    wr(OFS_CLR, 16'h0001);
    wr(OFS_IEN, 16'h0000);
    wr(OFS_CTL1, 16'h8402);
    repeat (150) @(posedge aclk);
    chk("masked_irq", irq, 0);
    rchk("masked_st", OFS_STAT, 32'h0001);
    wr(OFS_CLR, 16'h0001);
    wr(OFS_IEN, 16'h0001);
  endtask
  task automatic t_off();
    wr(OFS_CTL1, 16'h0400);
    wr(OFS_CTL1, 16'h0402);
    wirq();
    chk("off_hold", seen, 0);
    rchk("off_st", OFS_STAT, 0);
  endtask
  task automatic t_ext();
    wr(OFS_CTL1, 16'h8520);
    rchk("fmt", OFS_CTL1, 32'h8521);
    fire <= 1;
    @(posedge aclk);
    fire <= 0;
    wirq();
    chk("ext_irq", irq, 1);
    rchk("sint", OFS_RES0, {16'h0000, 16'(lvl(0)) - 16'h0800});
    // free-running trigger with left-aligned result
    wr(OFS_CLR, 16'h0003);
    wr(OFS_CTL1, 16'h86e0);
    wirq();
    chk("auto_irq", irq, 1);
    rchk("frac", OFS_RES0, {16'h0000, lvl(0), 4'h0});
    wr(OFS_CTL1, 16'h0000);
    rchk("auto_off", OFS_CTL1, 32'h0401);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_quad();
    t_single();
    t_off();
    t_ext();
    conclude();
  end
endmodule
